// ---- rtl/btrs_pkg.sv ----
// Shared constants and types for the bonded transceiver reset sequencer
package btrs_pkg;
	// Clock and fixed sequence times
	localparam int CLK_PERIOD_NS = 4;
	localparam int PLL_RST_NS = 1000;
	localparam int PLL_RST_CYC = (PLL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_PULSE_PCLK = 2;
	localparam int BUSY_GAP_PCLK = 2;
	localparam int CNT_W = 16;
	// Transmit sub-blocks: phase FIFO, byte serializer, encoder, serializer, XAUI FSM
	localparam int TXB_W = 5;
	// Receive sub-blocks: aligner, deskew, rate FIFO, decoder, byte deser,
	// byte ordering, phase FIFO, XAUI FSMs, BIST verifiers
	localparam int RXB_W = 9;
	// Register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam int CTRL_W = 4;
	localparam int CTRL_START = 0;
	localparam int CTRL_RX = 1;
	localparam int CTRL_MANUAL = 2;
	localparam int CTRL_PDOWN = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h2;
	localparam int ST_BUSY = 0;
	localparam int ST_PLL = 1;
	localparam int ST_ALLLK = 2;
	localparam int ST_OFFS = 3;
	localparam int ST_READY = 4;
	localparam int ST_STATE = 8;
	localparam int STATE_W = 4;

	typedef logic [ADDR_W-1:0] btrs_addr_t;
	typedef logic [DATA_W-1:0] btrs_data_t;
	typedef enum logic [1:0] {LK_AUTO, LK_REF, LK_DATA} btrs_lock_t;
	typedef enum logic [1:0] {BZ_FIRST, BZ_OFFSET, BZ_IDLE, BZ_ACCESS} btrs_busy_t;
	typedef enum logic [STATE_W-1:0] {
		CS_PLL_RST, CS_PLL_WAIT, CS_BUSY_WAIT, CS_CDR_GAP, CS_REF_WAIT,
		CS_CDR_WAIT, CS_SETTLE, CS_READY
	} btrs_state_t;
endpackage : btrs_pkg

// ---- rtl/btrs_if.sv ----
// Reset, lock-mode and status wires between transceiver block and its controller
`timescale 1ns/1ps
`default_nettype none
interface btrs_if #(parameter int N_CH = 4);
	logic pll_reset;
	logic tx_logic_reset;
	logic rx_logic_reset;
	logic [N_CH-1:0] rx_cdr_reset;
	logic block_powerdown;
	logic [N_CH-1:0] hold_ref;
	logic [N_CH-1:0] force_data;
	logic pll_locked;
	logic busy;
	logic [N_CH-1:0] cdr_locked;

	modport dev (
		input pll_reset, tx_logic_reset, rx_logic_reset, rx_cdr_reset, block_powerdown,
		input hold_ref, force_data,
		output pll_locked, busy, cdr_locked
	);
	modport ctl (
		output pll_reset, tx_logic_reset, rx_logic_reset, rx_cdr_reset, block_powerdown,
		output hold_ref, force_data,
		input pll_locked, busy, cdr_locked
	);
endinterface : btrs_if
`default_nettype wire

// ---- rtl/btrs_tick.sv ----
// Clock divider giving a one-cycle enable pulse every DIV cycles
`timescale 1ns/1ps
`default_nettype none
module btrs_tick #(
	parameter int DIV = 4
) (
	input wire logic clock,
	input wire logic rst,
	output logic tick
);
	import btrs_pkg::*;
	localparam int W = $clog2(DIV);

	if (DIV < 2) $error("btrs_tick: DIV must be at least 2");

	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} btrs_tick_st_t;

	btrs_tick_st_t q, d;

	always_comb begin
		d = q;
		d.tick = (q.cnt == W'(DIV - 1));
		d.cnt = d.tick ? '0 : q.cnt + 1'b1;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;
endmodule : btrs_tick
`default_nettype wire

// ---- rtl/btrs_device.sv ----
// Transceiver block end: reset fan-out, PLL, busy and per-channel CDR lock
`timescale 1ns/1ps
`default_nettype none
module btrs_device #(
	parameter int N_CH = 4,
	parameter int PDIV = 4,
	parameter int RDIV = 8,
	parameter int PLL_LOCK_T = 40,
	parameter int OFFSET_T = 30,
	parameter int ACCESS_T = 6,
	parameter int CDR_LOCK_T = 20,
	parameter int CDR_STAGGER = 3
) (
	input wire logic clock,
	input wire logic rst,
	btrs_if.dev link,
	input wire logic recfg_access,
	output logic pll_clr,
	output logic [btrs_pkg::TXB_W-1:0] tx_block_clr,
	output logic tx_buffer_off,
	output logic [btrs_pkg::RXB_W-1:0] rx_block_clr,
	output logic [N_CH-1:0] cdr_clr,
	output logic rx_analog_off,
	output logic [N_CH-1:0][1:0] cdr_mode
);
	import btrs_pkg::*;

	if (N_CH < 1) $error("btrs_device: N_CH must be at least 1");
	if (PLL_LOCK_T < 1 || OFFSET_T < 1 || ACCESS_T < 1 || CDR_LOCK_T < 1)
		$error("btrs_device: lock and busy times must be at least 1");
	if (CDR_LOCK_T + (N_CH - 1) * CDR_STAGGER >= 2 ** CNT_W)
		$error("btrs_device: CDR lock time too long for counter");
	if (PLL_LOCK_T >= 2 ** CNT_W || OFFSET_T >= 2 ** CNT_W || ACCESS_T >= 2 ** CNT_W)
		$error("btrs_device: time too long for counter");

	typedef struct packed {
		logic [CNT_W-1:0] pll_cnt;
		logic pll_lock;
		btrs_busy_t bphase;
		logic [CNT_W-1:0] bcnt;
		logic busy;
		logic acc_pend;
		logic [N_CH-1:0][CNT_W-1:0] ccnt;
		logic [N_CH-1:0] cdr_flag;
		logic pll_clr;
		logic [TXB_W-1:0] tx_clr;
		logic tx_off;
		logic [RXB_W-1:0] rx_clr;
		logic [N_CH-1:0] cdr_clr;
		logic rx_off;
		logic [N_CH-1:0][1:0] mode;
	} btrs_dev_st_t;

	btrs_dev_st_t q, d;
	logic ptick;
	logic rtick;

	// Manual pair decodes to a lock source; both low means automatic
	function automatic btrs_lock_t lock_mode(input logic href, input logic fdata);
		btrs_lock_t m;
		m = LK_AUTO;
		if (fdata) begin
			m = LK_DATA;
		end else if (href) begin
			m = LK_REF;
		end
		return m;
	endfunction : lock_mode

	btrs_tick #(.DIV(PDIV)) u_ptick (
		.clock(clock),
		.rst(rst),
		.tick(ptick)
	);

	btrs_tick #(.DIV(RDIV)) u_rtick (
		.clock(clock),
		.rst(rst),
		.tick(rtick)
	);

	always_comb begin
		btrs_lock_t m;
		logic [CNT_W-1:0] lim;
		m = LK_AUTO;
		lim = '0;
		d = q;

		// PLL answers to its own reset only; power-off leaves it running
		d.pll_clr = link.pll_reset;
		if (link.pll_reset) begin
			d.pll_cnt = '0;
			d.pll_lock = 1'b0;
		end else if (ptick && !q.pll_lock) begin
			if (q.pll_cnt == CNT_W'(PLL_LOCK_T - 1)) begin
				d.pll_lock = 1'b1;
			end else begin
				d.pll_cnt = q.pll_cnt + 1'b1;
			end
		end

		// Fan-out of channel resets to the sub-blocks
		d.tx_clr = {TXB_W{link.tx_logic_reset | link.block_powerdown}};
		d.tx_off = link.block_powerdown;
		d.rx_clr = {RXB_W{link.rx_logic_reset | link.block_powerdown}};
		d.rx_off = link.block_powerdown;
		d.cdr_clr = link.rx_cdr_reset | {N_CH{link.block_powerdown}};

		// Access held until served, so one arriving mid-pulse is kept
		d.acc_pend = q.acc_pend | recfg_access;
		if (rtick) begin
			case (q.bphase)
				BZ_FIRST: begin
					d.bphase = BZ_OFFSET;
					d.busy = 1'b1;
					d.bcnt = '0;
				end
				BZ_OFFSET, BZ_ACCESS: begin
					lim = (q.bphase == BZ_OFFSET) ? CNT_W'(OFFSET_T - 1) : CNT_W'(ACCESS_T - 1);
					if (q.bcnt == lim) begin
						d.busy = 1'b0;
						d.bphase = BZ_IDLE;
					end else begin
						d.bcnt = q.bcnt + 1'b1;
					end
				end
				BZ_IDLE: begin
					if (q.acc_pend) begin
						d.acc_pend = recfg_access;
						d.busy = 1'b1;
						d.bphase = BZ_ACCESS;
						d.bcnt = '0;
					end
				end
				default: begin
					d.bphase = BZ_IDLE;
					d.busy = 1'b0;
				end
			endcase
		end

		// Channel CDRs lock on their own schedule
		for (int i = 0; i < N_CH; i++) begin
			m = lock_mode(link.hold_ref[i], link.force_data[i]);
			d.mode[i] = 2'(m);
			if (link.rx_cdr_reset[i] || link.block_powerdown) begin
				d.ccnt[i] = '0;
				d.cdr_flag[i] = 1'b0;
			end else if (m == LK_REF) begin
				d.ccnt[i] = '0;
				d.cdr_flag[i] = 1'b0;
			end else if (ptick && !q.cdr_flag[i]) begin
				if (q.ccnt[i] == CNT_W'(CDR_LOCK_T + i * CDR_STAGGER - 1)) begin
					d.cdr_flag[i] = 1'b1;
				end else begin
					d.ccnt[i] = q.ccnt[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.bphase <= BZ_FIRST;
			q.pll_clr <= 1'b1;
			q.tx_clr <= '1;
			q.rx_clr <= '1;
			q.cdr_clr <= '1;
		end else begin
			q <= d;
		end
	end

	assign link.pll_locked = q.pll_lock;
	assign link.busy = q.busy;
	assign link.cdr_locked = q.cdr_flag;
	assign pll_clr = q.pll_clr;
	assign tx_block_clr = q.tx_clr;
	assign tx_buffer_off = q.tx_off;
	assign rx_block_clr = q.rx_clr;
	assign cdr_clr = q.cdr_clr;
	assign rx_analog_off = q.rx_off;
	assign cdr_mode = q.mode;
endmodule : btrs_device
`default_nettype wire

// ---- rtl/btrs_ctrl.sv ----
// Reset controller end: bonded power-up and reset sequence with register port
`timescale 1ns/1ps
`default_nettype none
module btrs_ctrl #(
	parameter int N_CH = 4,
	parameter int PDIV = 4,
	parameter int PLL_RST_T = btrs_pkg::PLL_RST_CYC,
	parameter int AUTO_SETTLE_T = 100,
	parameter int REF_DATA_T = 100,
	parameter int LTD_MAN_T = 100
) (
	input wire logic clock,
	input wire logic rst,
	btrs_if.ctl link,
	input wire btrs_pkg::btrs_addr_t addr,
	input wire btrs_pkg::btrs_data_t wdata,
	input wire logic wr,
	input wire logic rd,
	output btrs_pkg::btrs_data_t rdata
);
	import btrs_pkg::*;

	if (PLL_RST_T < PLL_RST_CYC) $error("btrs_ctrl: PLL reset shorter than 1 us");
	if (PLL_RST_T < MIN_PULSE_PCLK * PDIV) $error("btrs_ctrl: PLL reset below reset pulse minimum");
	if (AUTO_SETTLE_T < 1 || REF_DATA_T < 1 || LTD_MAN_T < 1) $error("btrs_ctrl: waits must be >= 1");
	if (PLL_RST_T >= 2 ** CNT_W || AUTO_SETTLE_T >= 2 ** CNT_W || REF_DATA_T >= 2 ** CNT_W
		|| LTD_MAN_T >= 2 ** CNT_W) $error("btrs_ctrl: wait too long for counter");

	typedef struct packed {
		btrs_state_t state;
		logic [CNT_W-1:0] cnt;
		logic [CTRL_W-1:0] ctrl;
		logic pll_rst;
		logic tx_rst;
		logic rx_rst;
		logic cdr_rst;
		logic href;
		logic fdata;
		logic busy_prev;
		logic offset_done;
		btrs_data_t rdata;
	} btrs_ctl_st_t;

	btrs_ctl_st_t q, d;
	logic ptick;

	btrs_tick #(.DIV(PDIV)) u_ptick (
		.clock(clock),
		.rst(rst),
		.tick(ptick)
	);

	always_comb begin
		logic all_lk;
		logic start;
		btrs_data_t status;
		all_lk = &link.cdr_locked;
		start = wr && (addr == REG_CTRL) && wdata[CTRL_START];
		status = '0;
		d = q;
		d.rdata = '0;
		d.busy_prev = link.busy;
		// Offset cancellation seen once stays done until power-up reset
		if (q.busy_prev && !link.busy) begin
			d.offset_done = 1'b1;
		end

		if (wr && addr == REG_CTRL) begin
			d.ctrl = wdata[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_START);
		end
		status[ST_BUSY] = link.busy;
		status[ST_PLL] = link.pll_locked;
		status[ST_ALLLK] = all_lk;
		status[ST_OFFS] = q.offset_done;
		status[ST_READY] = (q.state == CS_READY);
		status[ST_STATE +: STATE_W] = q.state;
		if (rd) begin
			case (addr)
				REG_CTRL: d.rdata = DATA_W'(q.ctrl);
				REG_STATUS: d.rdata = status;
				default: d.rdata = '0;
			endcase
		end

		case (q.state)
			CS_PLL_RST: begin
				if (q.cnt == CNT_W'(PLL_RST_T - 1)) begin
					d.pll_rst = 1'b0;
					d.state = CS_PLL_WAIT;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			CS_PLL_WAIT: begin
				if (link.pll_locked) begin
					d.tx_rst = 1'b0;
					d.state = q.ctrl[CTRL_RX] ? CS_BUSY_WAIT : CS_READY;
				end
			end
			CS_BUSY_WAIT: begin
				if (q.offset_done && !link.busy) begin
					d.cnt = '0;
					d.state = CS_CDR_GAP;
				end
			end
			CS_CDR_GAP: begin
				if (link.busy) begin
					d.state = CS_BUSY_WAIT;
				end else if (ptick) begin
					// First tick may come at once, so one more keeps two whole periods
					if (q.cnt == CNT_W'(BUSY_GAP_PCLK)) begin
						d.cdr_rst = 1'b0;
						d.cnt = '0;
						d.state = q.ctrl[CTRL_MANUAL] ? CS_REF_WAIT : CS_CDR_WAIT;
					end else begin
						d.cnt = q.cnt + 1'b1;
					end
				end
			end
			CS_REF_WAIT: begin
				if (q.cnt == CNT_W'(REF_DATA_T - 1)) begin
					d.href = 1'b0;
					d.fdata = 1'b1;
					d.cnt = '0;
					d.state = CS_SETTLE;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			CS_CDR_WAIT: begin
				d.cnt = '0;
				if (all_lk) begin
					d.state = CS_SETTLE;
				end
			end
			CS_SETTLE: begin
				// A lock flag dropping restarts the automatic settle
				if (!q.ctrl[CTRL_MANUAL] && !all_lk) begin
					d.state = CS_CDR_WAIT;
				end else if (q.cnt == CNT_W'((q.ctrl[CTRL_MANUAL] ? LTD_MAN_T : AUTO_SETTLE_T) - 1)) begin
					d.rx_rst = 1'b0;
					d.state = CS_READY;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
			CS_READY: d.cnt = '0;
			default: d.state = CS_READY;
		endcase

		// Restart: all resets go up together and stay up for the PLL pulse
		if (start) begin
			d.state = CS_PLL_RST;
			d.cnt = '0;
			d.pll_rst = 1'b1;
			d.tx_rst = 1'b1;
			d.rx_rst = 1'b1;
			d.cdr_rst = 1'b1;
			d.href = d.ctrl[CTRL_MANUAL];
			d.fdata = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.state <= CS_PLL_RST;
			q.ctrl <= CTRL_RST;
			q.pll_rst <= 1'b1;
			q.tx_rst <= 1'b1;
			q.rx_rst <= 1'b1;
			q.cdr_rst <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Bonded group: every channel gets the same reset and lock-mode drive
	assign link.pll_reset = q.pll_rst;
	assign link.tx_logic_reset = q.tx_rst;
	assign link.rx_logic_reset = q.rx_rst;
	assign link.rx_cdr_reset = {N_CH{q.cdr_rst}};
	assign link.block_powerdown = q.ctrl[CTRL_PDOWN];
	assign link.hold_ref = {N_CH{q.href}};
	assign link.force_data = {N_CH{q.fdata}};
	assign rdata = q.rdata;
endmodule : btrs_ctrl
`default_nettype wire

// ---- test/btrs_checker.sv ----
// Assertions on the link between the transceiver block and its reset controller
`timescale 1ns/1ps
`default_nettype none
module btrs_checker #(
	parameter int N_CH = 4,
	parameter int PDIV = 4,
	parameter int PLL_RST_T = 250,
	parameter int AUTO_SETTLE_T = 5
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic pll_reset,
	input wire logic tx_logic_reset,
	input wire logic rx_logic_reset,
	input wire logic [N_CH-1:0] rx_cdr_reset,
	input wire logic block_powerdown,
	input wire logic [N_CH-1:0] hold_ref,
	input wire logic [N_CH-1:0] force_data,
	input wire logic pll_locked,
	input wire logic busy,
	input wire logic [N_CH-1:0] cdr_locked
);
	import btrs_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [15:0] hi_q;
	logic [15:0] lk_q;
	logic [15:0] idle_q;
	// Run lengths of reset high, all-locked and busy low
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hi_q <= 16'h0;
			lk_q <= 16'h0;
			idle_q <= 16'h0;
		end else begin
			hi_q <= pll_reset ? hi_q + 16'h1 : 16'h0;
			lk_q <= (&cdr_locked) ? lk_q + 16'h1 : 16'h0;
			idle_q <= busy ? 16'h0 : idle_q + 16'h1;
		end
	end
	a_pll_holds_all: assert property (pll_reset |-> tx_logic_reset && rx_logic_reset && (&rx_cdr_reset))
		else $error("logic or CDR reset released during PLL reset");
	// Counting starts at reset release, so one cycle of slack
	a_pll_pulse_len: assert property ($fell(pll_reset) |-> hi_q >= PLL_RST_T - 1)
		else $error("PLL reset pulse too short");
	a_tx_after_lock: assert property ($fell(tx_logic_reset) |-> pll_locked)
		else $error("transmit logic released before PLL lock");
	a_pll_lock_time: assert property ($fell(pll_reset) |-> ##[1:200] pll_locked)
		else $error("PLL lock missing after reset release");
	a_pll_rst_unlock: assert property (pll_reset [*2] |-> !pll_locked)
		else $error("PLL lock shown while PLL held in reset");
	a_busy_first_low: assert property ($fell(rst) |-> !busy [*6])
		else $error("busy high in first reconfig cycle");
	a_cdr_gap: assert property ($fell(rx_cdr_reset[0]) |-> !busy && idle_q >= BUSY_GAP_PCLK * PDIV)
		else $error("CDR reset released too soon after busy");
	a_settle_auto: assert property ($fell(rx_logic_reset) && !(|force_data) |-> lk_q >= AUTO_SETTLE_T)
		else $error("receive logic released before settle time");
	a_ref_unlock: assert property ((hold_ref[0] && !force_data[0]) [*2] |-> !cdr_locked[0])
		else $error("lock flag high in reference mode");
	a_cdr_rst_unlock: assert property (rx_cdr_reset[0] [*2] |-> !cdr_locked[0])
		else $error("lock flag high while CDR in reset");
	a_pdown_spares: assert property (block_powerdown && pll_locked && !pll_reset |=> pll_locked)
		else $error("power-off disturbed PLL lock");
endmodule : btrs_checker
`default_nettype wire

// ---- test/test_bonded_transceiver_reset_sequencer.sv ----
// Power-up, access, power-off and manual-lock runs across both ends
`timescale 1ns/1ps
`default_nettype none
module test_bonded_transceiver_reset_sequencer;
	import btrs_pkg::*;
	// Short settle waits keep the run brief
	localparam int SIM_WAIT_T = 5;
	logic clock;
	logic rst;
	logic recfg_access;
	btrs_addr_t addr;
	btrs_data_t wdata;
	logic wr;
	logic rd;
	btrs_data_t rdata;
	btrs_data_t v;
	logic pll_clr;
	logic [TXB_W-1:0] tx_block_clr;
	logic tx_buffer_off;
	logic [RXB_W-1:0] rx_block_clr;
	logic [3:0] cdr_clr;
	logic rx_analog_off;
	logic [3:0][1:0] cdr_mode;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	btrs_if link ();
	btrs_device i_btrs_device (.clock(clock), .rst(rst), .link(link.dev),
		.recfg_access(recfg_access), .pll_clr(pll_clr), .tx_block_clr(tx_block_clr),
		.tx_buffer_off(tx_buffer_off), .rx_block_clr(rx_block_clr), .cdr_clr(cdr_clr),
		.rx_analog_off(rx_analog_off), .cdr_mode(cdr_mode));
	btrs_ctrl #(.AUTO_SETTLE_T(SIM_WAIT_T), .REF_DATA_T(SIM_WAIT_T),
		.LTD_MAN_T(SIM_WAIT_T)) i_btrs_ctrl (.clock(clock),
		.rst(rst), .link(link.ctl), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	btrs_checker #(.PLL_RST_T(PLL_RST_CYC), .AUTO_SETTLE_T(SIM_WAIT_T)) i_btrs_checker (
		.clock(clock), .rst(rst), .pll_reset(link.pll_reset),
		.tx_logic_reset(link.tx_logic_reset), .rx_logic_reset(link.rx_logic_reset),
		.rx_cdr_reset(link.rx_cdr_reset), .block_powerdown(link.block_powerdown),
		.hold_ref(link.hold_ref), .force_data(link.force_data), .pll_locked(link.pll_locked),
		.busy(link.busy), .cdr_locked(link.cdr_locked));

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(input btrs_data_t seen, input btrs_data_t exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr_reg(input btrs_addr_t a, input btrs_data_t d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input btrs_addr_t a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic wait_ready();
		for (int i = 0; i < 3000; i++) begin
			rd_reg(REG_STATUS);
			if (v[ST_READY] === 1'b1) return;
		end
		failures++;
	endtask : wait_ready

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// A hang costs a mismatch, not a silent stall
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end

	initial begin
		rst = 1'b1;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		recfg_access = 1'b0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1 check(32'({pll_clr, tx_buffer_off, rx_analog_off}), 32'h4);
		check(32'({tx_block_clr, rx_block_clr, cdr_clr}), 32'h3FFFF);
		for (int i = 0; i < 3000 && link.cdr_locked[0] !== 1'b1; i++) @(posedge clock);
		#1 check(32'(link.cdr_locked), 32'h1);
		wait_ready();
		check(32'(v[11:8]), 32'h7);
		check(32'(v[ST_OFFS]), 32'h1);
		check(32'({tx_block_clr, rx_block_clr, cdr_clr, pll_clr}), 32'h0);
		check(32'(cdr_mode), 32'h0);
		check(32'(link.busy), 32'h0);
		$display("Test auto power-up done");
		@(posedge clock);
		recfg_access <= 1'b1;
		@(posedge clock);
		recfg_access <= 1'b0;
		repeat (20) @(posedge clock);
		#1 check(32'(link.busy), 32'h1);
		repeat (80) @(posedge clock);
		#1 check(32'(link.busy), 32'h0);
		rd_reg(4'h8);
		check(v, 32'h0);
		$display("Test reconfig access done");
		wr_reg(REG_CTRL, 32'hA);
		repeat (3) @(posedge clock);
		#1 check(32'({pll_clr, tx_buffer_off, rx_analog_off, link.pll_locked}), 32'h7);
		check(32'({tx_block_clr, rx_block_clr, cdr_clr}), 32'h3FFFF);
		wr_reg(REG_CTRL, 32'h2);
		$display("Test power-off done");
		wr_reg(REG_CTRL, 32'h7);
		repeat (2) @(posedge clock);
		#1 check(32'({pll_clr, tx_block_clr}), 32'h3F);
		for (int i = 0; i < 3000 && link.hold_ref[0] !== 1'b1; i++) @(posedge clock);
		repeat (2) @(posedge clock);
		#1 check(32'(cdr_mode), 32'h55);
		check(32'(link.cdr_locked), 32'h0);
		for (int i = 0; i < 3000 && link.force_data[0] !== 1'b1; i++) @(posedge clock);
		repeat (2) @(posedge clock);
		#1 check(32'(cdr_mode), 32'hAA);
		wait_ready();
		check(32'({rx_block_clr, link.busy}), 32'h0);
		rd_reg(REG_CTRL);
		check(v, 32'h6);
		$display("Test manual restart done");
		end_sim();
	end
endmodule : test_bonded_transceiver_reset_sequencer
`default_nettype wire
